// [hdl/alusx_top.sv]
// Purpose: apb-controlled datapath for sub-borrow, swap, xor, direction load
// Assumes: apb master holds the request until pready, one clock pclk
// Notes:   a command executes in the cycle after its write completes
`timescale 1ns/1ps
//
// Contract
// RULE_01: subtract does file minus accumulator minus borrow; sets c, dc, z.
// RULE_02: subtract and xor-file write accumulator on dest 0, file on dest 1.
// RULE_03: swap exchanges file register nibbles, writes chosen destination.
// RULE_04: direction load copies accumulator to port a/b/c on 5/6/7; no flags.
// RULE_05: xor-literal: acc xor 8-bit immediate into acc; only z changes.
// RULE_06: xor-file xors accumulator with file register into dest; z only.
// RULE_07: zero flag set when the affected 8-bit result is zero, else cleared.
module alusx_top
	import alusx_pkg::*;
(
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// apb slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// port direction registers
	output logic      [alusx_pkg::DW-1:0] port_a_direction,
	output logic      [alusx_pkg::DW-1:0] port_b_direction,
	output logic      [alusx_pkg::DW-1:0] port_c_direction
);
	import alusx_pkg::*;

	// strobe aimed at one register offset
	function automatic logic reg_hit(input logic strobe,
		input logic [7:0] addr, input logic [7:0] off);
		return strobe && (addr == off);
	endfunction

	// one data byte zero-extended to a bus word
	function automatic logic [31:0] byte_word(input logic [DW-1:0] b);
		return {{(32-DW){1'b0}}, b};
	endfunction

	// command register as software reads it back, same field positions
	function automatic logic [31:0] cmd_word(input alusx_cmd_s c);
		logic [31:0] w;
		w                      = ZERO_W;
		w[CMD_LIT_LSB +: DW]   = c.lit;
		w[CMD_FADDR_LSB +: AW] = c.faddr;
		w[CMD_DEST_BIT]        = c.dest;
		w[CMD_OP_LSB +: OP_W]  = c.op;
		return w;
	endfunction

	logic [DW-1:0] mem [DEPTH];

	logic [31:0]   prdata_ff;
	logic [31:0]   nxt_prdata;
	logic          pready_ff;
	logic          pslverr_ff;
	logic          nxt_pslverr;
	logic [DW-1:0] acc_ff;
	alusx_flags_s  flags_ff;
	alusx_cmd_s    cmd_ff;
	logic          go_ff;
	logic [AW-1:0] faddr_ff;
	logic [DW-1:0] dir_a_ff;
	logic [DW-1:0] dir_b_ff;
	logic [DW-1:0] dir_c_ff;

	logic          acc_phase;
	logic          done;
	logic          wr;
	logic          wr_cmd;
	logic          wr_acc;
	logic          wr_status;
	logic          wr_faddr;
	logic          wr_fdata;
	logic          mapped;
	logic [DW-1:0] fval;
	alusx_res_s    res;

	assign prdata           = prdata_ff;
	assign pready           = pready_ff;
	assign pslverr          = pslverr_ff;
	assign port_a_direction = dir_a_ff;
	assign port_b_direction = dir_b_ff;
	assign port_c_direction = dir_c_ff;

	// one wait state: answer comes on the second access cycle
	assign acc_phase = psel & penable;
	assign done      = acc_phase & pready_ff;
	assign wr        = done & pwrite & ~pslverr_ff;
	assign fval      = mem[cmd_ff.faddr];

	// per-register write strobes
	assign wr_cmd    = reg_hit(wr, paddr, OFF_CMD);
	assign wr_acc    = reg_hit(wr, paddr, OFF_ACC);
	assign wr_status = reg_hit(wr, paddr, OFF_STATUS);
	assign wr_faddr  = reg_hit(wr, paddr, OFF_FADDR);
	assign wr_fdata  = reg_hit(wr, paddr, OFF_FDATA);

	alusx_alu u_alu (
		.cmd      (cmd_ff),
		.acc      (acc_ff),
		.fval     (fval),
		.flags_in (flags_ff),
		.res      (res)
	);

	// address decode and read mux
	always_comb begin
		mapped     = 1'b1;
		nxt_prdata = ZERO_W;
		unique case (paddr)
			OFF_CMD:    nxt_prdata = cmd_word(cmd_ff);
			OFF_ACC:    nxt_prdata = byte_word(acc_ff);
			OFF_STATUS: nxt_prdata = {29'h0000_0000, flags_ff};
			OFF_FADDR:  nxt_prdata = {25'h000_0000, faddr_ff};
			OFF_FDATA:  nxt_prdata = byte_word(mem[faddr_ff]);
			OFF_DIR:    nxt_prdata = {8'h00, dir_c_ff, dir_b_ff, dir_a_ff};
			default:    mapped = 1'b0;
		endcase
		nxt_pslverr = ~mapped | reg_hit(pwrite, paddr, OFF_DIR);
	end

	// apb handshake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= ZERO_W;
		end else if (acc_phase & ~pready_ff) begin
			pready_ff  <= 1'b1;
			pslverr_ff <= nxt_pslverr;
			prdata_ff  <= pwrite ? ZERO_W : nxt_prdata;
		end else begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= ZERO_W;
		end
	end

	// command capture, executes one cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_ff <= '0;
			go_ff  <= 1'b0;
		end else if (wr_cmd) begin
			cmd_ff.lit   <= pwdata[CMD_LIT_LSB +: DW];
			cmd_ff.faddr <= pwdata[CMD_FADDR_LSB +: AW];
			cmd_ff.dest  <= pwdata[CMD_DEST_BIT];
			cmd_ff.op    <= pwdata[CMD_OP_LSB +: OP_W];
			go_ff        <= 1'b1;
		end else begin
			go_ff <= 1'b0;
		end
	end

	// file address pointer for software access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			faddr_ff <= '0;
		end else if (wr_faddr) begin
			faddr_ff <= pwdata[AW-1:0];
		end
	end

	// accumulator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_ff <= ACC_RST;
		end else if (go_ff && res.to_acc) begin
			acc_ff <= res.result; // [RULE_02] [RULE_03] [RULE_05]
		end else if (wr_acc) begin
			acc_ff <= pwdata[DW-1:0];
		end
	end

	// status flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_ff <= '0;
		end else if (go_ff && (res.upd_c || res.upd_z)) begin
			if (res.upd_c) begin
				flags_ff.c  <= res.flags.c; // [RULE_01]
				flags_ff.dc <= res.flags.dc; // [RULE_01]
			end
			flags_ff.z <= res.flags.z; // [RULE_07]
		end else if (wr_status) begin
			flags_ff.c  <= pwdata[ST_C_BIT];
			flags_ff.dc <= pwdata[ST_DC_BIT];
			flags_ff.z  <= pwdata[ST_Z_BIT];
		end
	end

	// file register memory
	always_ff @(posedge pclk) begin
		if (go_ff && res.to_file) begin
			mem[cmd_ff.faddr] <= res.result; // [RULE_02] [RULE_03] [RULE_06]
		end else if (wr_fdata) begin
			mem[faddr_ff] <= pwdata[DW-1:0];
		end
	end

	// port direction registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_a_ff <= DIR_RST;
			dir_b_ff <= DIR_RST;
			dir_c_ff <= DIR_RST;
		end else if (go_ff && res.to_dir) begin
			unique case (cmd_ff.faddr)
				SEL_PORT_A: dir_a_ff <= res.result; // [RULE_04]
				SEL_PORT_B: dir_b_ff <= res.result; // [RULE_04]
				SEL_PORT_C: dir_c_ff <= res.result; // [RULE_04]
				default: begin
				end
			endcase
		end
	end

endmodule

// [hdl/alusx_pkg.sv]
// Purpose: shared constants and types for the sub/swap/xor/direction datapath
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   byte offsets, field positions and reset values live here
package alusx_pkg;

	localparam int unsigned DW = 8;
	localparam int unsigned AW = 7;
	localparam int unsigned DEPTH = 128;

	// apb byte offsets
	localparam logic [7:0] OFF_CMD    = 8'h00;
	localparam logic [7:0] OFF_ACC    = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_FADDR  = 8'h0c;
	localparam logic [7:0] OFF_FDATA  = 8'h10;
	localparam logic [7:0] OFF_DIR    = 8'h14;

	// command word fields
	localparam int unsigned CMD_LIT_LSB   = 0;
	localparam int unsigned CMD_FADDR_LSB = 8;
	localparam int unsigned CMD_DEST_BIT  = 16;
	localparam int unsigned CMD_OP_LSB    = 24;
	localparam int unsigned OP_W          = 3;

	// status fields
	localparam int unsigned ST_C_BIT  = 0;
	localparam int unsigned ST_DC_BIT = 1;
	localparam int unsigned ST_Z_BIT  = 2;

	// direction word fields
	localparam int unsigned DIR_A_LSB = 0;
	localparam int unsigned DIR_B_LSB = 8;
	localparam int unsigned DIR_C_LSB = 16;

	// direction operand selectors
	localparam logic [AW-1:0] SEL_PORT_A = 7'h05;
	localparam logic [AW-1:0] SEL_PORT_B = 7'h06;
	localparam logic [AW-1:0] SEL_PORT_C = 7'h07;

	// destination select
	localparam logic DEST_ACC  = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	// reset values
	localparam logic [DW-1:0] ACC_RST = 8'h00;
	localparam logic [DW-1:0] DIR_RST = 8'hff;
	localparam logic [DW-1:0] ZERO_B  = 8'h00;
	localparam logic [31:0]   ZERO_W  = 32'h0000_0000;

	typedef enum logic [OP_W-1:0] {
		ALUSX_SUB_BORROW,
		ALUSX_NIBBLE_EXCHANGE,
		ALUSX_LOAD_DIRECTION,
		ALUSX_XOR_LITERAL,
		ALUSX_XOR_FILE
	} alusx_op_e;

	typedef struct packed {
		logic [OP_W-1:0] op;
		logic            dest;
		logic [AW-1:0]   faddr;
		logic [DW-1:0]   lit;
	} alusx_cmd_s;

	typedef struct packed {
		logic z;
		logic dc;
		logic c;
	} alusx_flags_s;

	// result of one datapath evaluation
	typedef struct packed {
		logic [DW-1:0] result;
		alusx_flags_s  flags;
		logic          upd_c;
		logic          upd_z;
		logic          to_file;
		logic          to_acc;
		logic          to_dir;
	} alusx_res_s;

endpackage

// [hdl/alusx_alu.sv]
// Purpose: combinational execution of one command
// Assumes: operands already fetched from accumulator and file memory
// Notes:   flags not updated keep the values passed in
`timescale 1ns/1ps
module alusx_alu
	import alusx_pkg::*;
(
	// operands
	input  wire alusx_pkg::alusx_cmd_s   cmd,
	input  wire logic [alusx_pkg::DW-1:0] acc,
	input  wire logic [alusx_pkg::DW-1:0] fval,
	input  wire alusx_pkg::alusx_flags_s flags_in,
	// result
	output alusx_pkg::alusx_res_s        res
);
	import alusx_pkg::*;

	function automatic logic is_zero(input logic [DW-1:0] v);
		return v == ZERO_B;
	endfunction

	logic [DW:0]   sum;
	logic [DW/2:0] half;

	// f + ~w + c is f - w - borrow
	assign sum  = {1'b0, fval} + {1'b0, ~acc} + {{DW{1'b0}}, flags_in.c};
	assign half = {1'b0, fval[DW/2-1:0]} + {1'b0, ~acc[DW/2-1:0]}
		+ {{(DW/2){1'b0}}, flags_in.c};

	always_comb begin
		res = '0;
		res.flags = flags_in;
		unique case (alusx_op_e'(cmd.op))
			ALUSX_SUB_BORROW: begin
				res.result   = sum[DW-1:0]; // [RULE_01]
				res.flags.c  = sum[DW]; // [RULE_01]
				res.flags.dc = half[DW/2]; // [RULE_01]
				res.flags.z  = is_zero(sum[DW-1:0]); // [RULE_07]
				res.upd_c    = 1'b1;
				res.upd_z    = 1'b1;
				res.to_file  = (cmd.dest == DEST_FILE); // [RULE_02]
				res.to_acc   = (cmd.dest == DEST_ACC); // [RULE_02]
			end
			ALUSX_NIBBLE_EXCHANGE: begin
				res.result  = {fval[DW/2-1:0], fval[DW-1:DW/2]}; // [RULE_03]
				res.to_file = (cmd.dest == DEST_FILE); // [RULE_03]
				res.to_acc  = (cmd.dest == DEST_ACC); // [RULE_03]
			end
			ALUSX_LOAD_DIRECTION: begin
				res.result = acc; // [RULE_04]
				res.to_dir = 1'b1; // [RULE_04]
			end
			ALUSX_XOR_LITERAL: begin
				res.result  = acc ^ cmd.lit; // [RULE_05]
				res.flags.z = is_zero(acc ^ cmd.lit); // [RULE_05] [RULE_07]
				res.upd_z   = 1'b1;
				res.to_acc  = 1'b1; // [RULE_05]
			end
			ALUSX_XOR_FILE: begin
				res.result  = acc ^ fval; // [RULE_06]
				res.flags.z = is_zero(acc ^ fval); // [RULE_06] [RULE_07]
				res.upd_z   = 1'b1;
				res.to_file = (cmd.dest == DEST_FILE); // [RULE_02]
				res.to_acc  = (cmd.dest == DEST_ACC); // [RULE_02]
			end
			default: begin
				res.result = ZERO_B;
			end
		endcase
	end

endmodule

// [testbench/alusx_props.sv]
// Purpose: bus and direction checks for alusx_top
// Assumes: one wait state per apb transfer
// Notes:   bound to every alusx_top
`timescale 1ns/1ps
module alusx_props
	import alusx_pkg::*;
(
	// clock and reset
	input wire logic                     pclk,
	input wire logic                     presetn,
	// apb
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [7:0]               paddr,
	input wire logic [31:0]              pwdata,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	// directions
	input wire logic [alusx_pkg::DW-1:0] port_a_direction,
	input wire logic [alusx_pkg::DW-1:0] port_b_direction,
	input wire logic [alusx_pkg::DW-1:0] port_c_direction
);
	import alusx_pkg::*;
	logic ld_dir;
	logic ld_a;
	logic ld_c;
	assign ld_dir = psel && penable && pready && pwrite && paddr == OFF_CMD
		&& pwdata[CMD_OP_LSB +: OP_W] == 3'h2;
	assign ld_a = ld_dir && pwdata[CMD_FADDR_LSB +: AW] == SEL_PORT_A;
	assign ld_c = ld_dir && pwdata[CMD_FADDR_LSB +: AW] == SEL_PORT_C;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_READY_ONE_WAIT: assert property ($rose(penable) && psel
		|-> !pready ##1 pready) else $error("apb wait state wrong");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready && psel)
		else $error("pslverr outside completion");
	AST_RDATA_IDLE: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
		else $error("prdata not zero outside read");
	AST_DIR_WRITE_ERR: assert property (pready && pwrite && paddr == OFF_DIR
		|-> pslverr) else $error("direction word write accepted");
	AST_DIR_READ: assert property (pready && !pwrite && paddr == OFF_DIR
		|-> prdata == {8'h00, port_c_direction, port_b_direction,
		port_a_direction}) else $error("direction word read wrong");
	AST_DIR_A_CAUSE: assert property ($changed(port_a_direction)
		|-> $past(ld_a, 2)) else $error("port a changed without load");
	AST_DIR_C_CAUSE: assert property ($changed(port_c_direction)
		|-> $past(ld_c, 2)) else $error("port c changed without load");
	cover property (ld_a);
	cover property (pready && pslverr);
	cover property (pready && !pwrite && paddr == OFF_ACC);
endmodule
bind alusx_top alusx_props alusx_props_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
	.port_c_direction(port_c_direction));

// [testbench/alusx_top_tb.sv]
// Purpose: self-checking bench for alusx_top
// Assumes: apb slave answers after one wait state
// Notes:   rows hold the arithmetic and logic commands
`timescale 1ns/1ps
module alusx_top_tb;
	import alusx_pkg::*;
	typedef struct packed {
		logic [7:0]  f, w;
		logic [2:0]  st;
		logic [31:0] cmd;
		logic [7:0]  ea, ef;
		logic [2:0]  est;
	} alusx_row_s;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, pready, pslverr, e;
	logic [7:0]  paddr = 8'h00, pa, pb, pc;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [7:0]  ed [3];
	int          miscompares = 0, checks_done = 0;
	alusx_row_s  rows [12] = '{
		'{8'h50, 8'h20, 3'h1, 32'h0000_7f00, 8'h30, 8'h50, 3'h3},
		'{8'h10, 8'h10, 3'h0, 32'h0001_7f00, 8'h10, 8'hff, 3'h0},
		'{8'h22, 8'h21, 3'h0, 32'h0000_7f00, 8'h00, 8'h22, 3'h7},
		'{8'h00, 8'h00, 3'h1, 32'h0000_7f00, 8'h00, 8'h00, 3'h7},
		'{8'h03, 8'h05, 3'h1, 32'h0000_7f00, 8'hfe, 8'h03, 3'h0},
		'{8'ha5, 8'h3c, 3'h5, 32'h0101_7f00, 8'h3c, 8'h5a, 3'h5},
		'{8'h0f, 8'h00, 3'h2, 32'h0100_7f00, 8'hf0, 8'h0f, 3'h2},
		'{8'h11, 8'hff, 3'h3, 32'h0300_00ff, 8'h00, 8'h11, 3'h7},
		'{8'h11, 8'hf0, 3'h4, 32'h0300_000f, 8'hff, 8'h11, 3'h0},
		'{8'h3c, 8'h3c, 3'h1, 32'h0400_7f00, 8'h00, 8'h3c, 3'h5},
		'{8'h0f, 8'hf0, 3'h7, 32'h0401_7f00, 8'hf0, 8'hff, 3'h3},
		'{8'h12, 8'h34, 3'h2, 32'h0501_7f00, 8'h34, 8'h12, 3'h2}};
	always #5 pclk = ~pclk;
	alusx_top alusx_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port_a_direction(pa), .port_b_direction(pb), .port_c_direction(pc));
	task automatic results;
		if (miscompares == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, x);
		checks_done++;
		if (s !== x) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 20) begin
			miscompares++;
			results();
		end
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0);
		chk(nm, r, x);
	endtask
	initial begin
		ed = '{8'hff, 8'hff, 8'hff};
		repeat (10) @(posedge pclk);
		chk("rst_ports", {8'h0, pc, pb, pa}, 32'h00ff_ffff);
		presetn <= 1'b1;
		@(posedge pclk);
		rc("rst_acc", OFF_ACC, 32'h0);
		rc("rst_cmd", OFF_CMD, 32'h0);
		xfer(1'b1, OFF_FADDR, 32'h7f);
		foreach (rows[i]) begin
			xfer(1'b1, OFF_FDATA, {24'h0, rows[i].f});
			xfer(1'b1, OFF_ACC, {24'h0, rows[i].w});
			xfer(1'b1, OFF_STATUS, {29'h0, rows[i].st});
			xfer(1'b1, OFF_CMD, rows[i].cmd);
			rc("cmd", OFF_CMD, rows[i].cmd);
			rc("acc", OFF_ACC, {24'h0, rows[i].ea});
			rc("file", OFF_FDATA, {24'h0, rows[i].ef});
			rc("status", OFF_STATUS, {29'h0, rows[i].est});
		end
		for (int k = 4; k < 8; k++) begin
			xfer(1'b1, OFF_STATUS, 32'h5);
			xfer(1'b1, OFF_ACC, 32'h40 + 32'(k));
			xfer(1'b1, OFF_CMD, 32'h0200_0000 + 32'(k) * 32'h100);
			if (k > 4) ed[k - 5] = 8'h40 + 8'(k);
			rc("dir_status", OFF_STATUS, 32'h5);
			chk("ports", {8'h0, pc, pb, pa}, {8'h0, ed[2], ed[1], ed[0]});
		end
		xfer(1'b1, OFF_DIR, 32'h0);
		chk("dir_err", {31'h0, e}, 32'h1);
		rc("dir", OFF_DIR, {8'h0, ed[2], ed[1], ed[0]});
		rc("bad_data", 8'h18, 32'h0);
		chk("bad_err", {31'h0, e}, 32'h1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("rst2_ports", {8'h0, pc, pb, pa}, 32'h00ff_ffff);
		presetn <= 1'b1;
		@(posedge pclk);
		rc("rst2_acc", OFF_ACC, 32'h0);
		results();
	end
endmodule
